/* common/shps_pkg.sv */
// Constants shared by the serial host port select block.
// Assumes a 10 MHz system clock and a host serial clock far slower than it.
package shps_pkg;

  // System clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Reset levels of pin samplers: the select pins are pulled up, so open pins read high
  localparam logic PIN_PULL_LEVEL = 1'b1;

  // Number of flops in each pin synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  // Number of sampled pins: mode, clock, data, select/addr0, addr1, addr2
  localparam int unsigned PIN_COUNT = 6;

  // Bit positions of the pins inside the sampled vector
  localparam int unsigned PIN_MODE = 0;
  localparam int unsigned PIN_CLK = 1;
  localparam int unsigned PIN_DATA = 2;
  localparam int unsigned PIN_SEL0 = 3;
  localparam int unsigned PIN_ADDR1 = 4;
  localparam int unsigned PIN_ADDR2 = 5;

  // Fixed upper four bits of the seven-bit slave address (value is arbitrary)
  localparam logic [3:0] I2C_ADDR_HI = 4'h5;

  // Bits per address byte, and counter width
  localparam logic [3:0] ADDR_BITS = 4'h8;

  // I2C slave sequencing states
  typedef enum logic [2:0] {
    SHPS_IDLE,
    SHPS_ADDR,
    SHPS_ACK_WAIT,
    SHPS_ACK,
    SHPS_BUSY,
    SHPS_SKIP
  } shps_i2c_state_t;

endpackage

/* design/shps_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level; no relation between bits is kept.
`timescale 1ns/1ps
module shps_sync
  import shps_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic RST_LEVEL = 1'b1
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Raw pin levels and synchronised copies
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_q;

  // Both stages reset to the pulled level so an open pin never looks asserted
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= {WIDTH{RST_LEVEL}};
      sync_o <= {WIDTH{RST_LEVEL}};
    end
    else
    begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end

endmodule

/* design/shps_port_sel.sv */
// Serial host port select: routes shared pins to SPI or I2C and drives the interrupt pin.
// Assumes the host clock is slow against clk_sys (8 samples per bit or more) and
// that the core behind it does the register work for both protocols.
`timescale 1ns/1ps

// Notes on behaviour
// - Select pin high gives I2C, low SPI
// - Clock pin: SPI clock, or I2C SCL
// - Data pin: SPI input, or I2C SDA
// - Output pin carries SPI read data only
// - Select pin: SPI chip select, or addr0
// - Two pulled-up pins give address bits 1, 2
// - Status change asserts interrupt until host reads
// - Interrupt is open-drain, active low
module shps_port_sel
  import shps_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Protocol select pin
  input wire logic i2c_en_pin,
  // Shared clock pin: input, output, output enable (low drives)
  input wire logic sck_scl_i,
  output logic sck_scl_o_q,
  output logic sck_scl_oe_n_q,
  // Shared data pin: input, output, output enable (low drives)
  input wire logic si_sda_i,
  output logic si_sda_o_q,
  output logic si_sda_oe_n_q,
  // Dedicated serial output pin
  output logic so_q,
  // Chip select or address bit pins
  input wire logic select_or_addr_bit0_pin,
  input wire logic i2c_addr_bit1,
  input wire logic i2c_addr_bit2,
  // Interrupt pin: output, output enable (low drives)
  output logic int_o_q,
  output logic int_oe_n_q,
  // Core side: mode and SPI signals
  output logic i2c_mode_q,
  output logic spi_sck_q,
  output logic spi_mosi_q,
  output logic spi_cs_n_q,
  input wire logic spi_miso,
  // Core side: I2C signals
  output logic [6:0] i2c_slave_addr_q,
  output logic i2c_hit_q,
  output logic i2c_rd_q,
  output logic i2c_active_q,
  output logic i2c_scl_q,
  output logic i2c_sda_q,
  input wire logic i2c_sda_pull,
  // Core side: interrupt events
  input wire logic status_change,
  input wire logic isr_read
);

  // Synchronised pin vector
  logic [PIN_COUNT-1:0] pins_s;
  // Previous synchronised clock and data, for edge finding
  logic clk_prev_q;
  logic data_prev_q;
  // I2C sequencer
  shps_i2c_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  // Interrupt pending flag
  logic irq_pend_q;

  // Decoded pin events
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;

  // Every pin passes two flops; pulled-up reset level keeps I2C chosen while open
  shps_sync #(
    .WIDTH(PIN_COUNT),
    .RST_LEVEL(PIN_PULL_LEVEL)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_i({i2c_addr_bit2, i2c_addr_bit1, select_or_addr_bit0_pin, si_sda_i, sck_scl_i, i2c_en_pin}),
    .sync_o(pins_s)
  );

  assign scl_s = pins_s[PIN_CLK];
  assign sda_s = pins_s[PIN_DATA];
  // Edges are found on synchronised copies only
  assign scl_rise = scl_s && !clk_prev_q;
  assign scl_fall = !scl_s && clk_prev_q;
  // Start and stop: data moves while the clock is high
  assign i2c_start = i2c_mode_q && scl_s && clk_prev_q && data_prev_q && !sda_s;
  assign i2c_stop = i2c_mode_q && scl_s && clk_prev_q && !data_prev_q && sda_s;

  // Protocol select follows the synchronised pin; it is static in use
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      i2c_mode_q <= PIN_PULL_LEVEL;
    else
      i2c_mode_q <= pins_s[PIN_MODE];
  end

  // SPI side: pins forwarded to the core, read data to the pin, only in SPI mode
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      spi_sck_q <= 1'b0;
      spi_mosi_q <= 1'b0;
      spi_cs_n_q <= 1'b1;
      so_q <= 1'b0;
    end
    else if (!i2c_mode_q)
    begin
      spi_sck_q <= scl_s;
      spi_mosi_q <= sda_s;
      spi_cs_n_q <= pins_s[PIN_SEL0];
      so_q <= spi_miso;
    end
    else
    begin
      // Chip select held off so the SPI core never sees I2C traffic
      spi_sck_q <= 1'b0;
      spi_mosi_q <= 1'b0;
      spi_cs_n_q <= 1'b1;
      so_q <= 1'b0;
    end
  end

  // I2C side: address bits, line copies for the core, and clock/data edge history
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      i2c_slave_addr_q <= {I2C_ADDR_HI, 3'h7};
      i2c_scl_q <= 1'b1;
      i2c_sda_q <= 1'b1;
      clk_prev_q <= PIN_PULL_LEVEL;
      data_prev_q <= PIN_PULL_LEVEL;
    end
    else
    begin
      // Address pins read high when open thanks to the pull-ups
      i2c_slave_addr_q <= {I2C_ADDR_HI, pins_s[PIN_ADDR2], pins_s[PIN_ADDR1], pins_s[PIN_SEL0]};
      i2c_scl_q <= i2c_mode_q ? scl_s : 1'b1;
      i2c_sda_q <= i2c_mode_q ? sda_s : 1'b1;
      clk_prev_q <= scl_s;
      data_prev_q <= sda_s;
    end
  end

  // I2C address sequencer: shift on clock rise, answer on the ninth clock
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= SHPS_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      i2c_hit_q <= 1'b0;
      i2c_rd_q <= 1'b0;
    end
    else if (!i2c_mode_q || i2c_stop)
    begin
      state_q <= SHPS_IDLE;
      i2c_hit_q <= 1'b0;
    end
    else if (i2c_start)
    begin
      // Repeated start also lands here
      state_q <= SHPS_ADDR;
      bit_cnt_q <= 4'h0;
      i2c_hit_q <= 1'b0;
    end
    else
    begin
      i2c_hit_q <= 1'b0;
      unique case (state_q)
        SHPS_ADDR:
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == ADDR_BITS - 4'h1)
              state_q <= SHPS_ACK_WAIT;
          end
        SHPS_ACK_WAIT:
          if (scl_fall)
          begin
            // Only a match is acknowledged; others are left to pass
            if (shift_q[7:1] == i2c_slave_addr_q)
            begin
              state_q <= SHPS_ACK;
              i2c_rd_q <= shift_q[0];
              i2c_hit_q <= 1'b1;
            end
            else
              state_q <= SHPS_SKIP;
          end
        SHPS_ACK:
          if (scl_fall)
            state_q <= SHPS_BUSY;
        // Waiting states hold until a stop or a start
        SHPS_IDLE, SHPS_BUSY, SHPS_SKIP:
          state_q <= state_q;
      endcase
    end
  end

  // Data pin drive: acknowledge, then core-requested pulls while addressed
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      si_sda_o_q <= 1'b0;
      si_sda_oe_n_q <= 1'b1;
      sck_scl_o_q <= 1'b0;
      sck_scl_oe_n_q <= 1'b1;
      i2c_active_q <= 1'b0;
    end
    else
    begin
      si_sda_o_q <= 1'b0;
      // Pulls only low; the bus pull-up gives the high level
      si_sda_oe_n_q <= !(i2c_mode_q && (state_q == SHPS_ACK || (state_q == SHPS_BUSY && i2c_sda_pull)));
      i2c_active_q <= i2c_mode_q && (state_q == SHPS_BUSY);
      // Clock pin is never stretched, so it stays released in both modes
      sck_scl_o_q <= 1'b0;
      sck_scl_oe_n_q <= 1'b1;
    end
  end

  // Interrupt pending: a new status change wins over a same-cycle read
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      irq_pend_q <= 1'b0;
    else if (status_change)
      irq_pend_q <= 1'b1;
    else if (isr_read)
      irq_pend_q <= 1'b0;
  end

  // Open-drain interrupt: output low, enable low while pending and for one cycle after the clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_o_q <= 1'b0;
      int_oe_n_q <= 1'b1;
    end
    else
    begin
      int_o_q <= 1'b0;
      int_oe_n_q <= !(irq_pend_q || status_change);
    end
  end

  // Checks
  mode_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pins_s[PIN_MODE] |=> (i2c_mode_q == 1'b1))
    else $error("mode does not follow select pin high");
  spi_clock_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!i2c_mode_q && !$past(i2c_mode_q)) |-> (spi_sck_q == $past(scl_s, 1) && sck_scl_oe_n_q))
    else $error("SPI clock not forwarded");
  sda_spi_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!i2c_mode_q [*2]) |-> si_sda_oe_n_q)
    else $error("data pin driven in SPI mode");
  so_route_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    i2c_mode_q |=> !so_q)
    else $error("serial output active in I2C mode");
  cs_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!i2c_mode_q && !pins_s[PIN_SEL0]) |=> !spi_cs_n_q)
    else $error("chip select not passed");
  addr_pins_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    1'b1 |=> i2c_slave_addr_q[2:1] == $past(pins_s[PIN_ADDR2:PIN_ADDR1]))
    else $error("address select bits wrong");
  irq_assert_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (status_change && isr_read) |=> !int_oe_n_q ##1 !int_oe_n_q)
    else $error("interrupt lost on clear");
  irq_release_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!irq_pend_q && !status_change) |=> (int_oe_n_q && !int_o_q))
    else $error("interrupt pin not released");
  ack_match_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (state_q == SHPS_ACK_WAIT && scl_fall && shift_q[7:1] != i2c_slave_addr_q) |=> ##1 si_sda_oe_n_q)
    else $error("acknowledge without address match");

endmodule

/* verif/shps_host_model.sv */
// Host master model: drives the shared clock, data and select lines.
// Assumes the bench resolves the open-drain data line with its pull-up.
`timescale 1ns/1ps
module shps_host_model
  import shps_pkg::*;
(
  // Resolved data line level
  input wire logic sda_line,
  // Host drives; data at 1 means released
  output logic sck_q,
  output logic sda_q,
  output logic cs_n_q
);
  // Idle: clock still, select high, data released
  initial
  begin
    sck_q = 1'b0;
    sda_q = 1'b1;
    cs_n_q = 1'b1;
  end

  // One SPI bit inside a select frame; clock stands still outside it
  task automatic spi_bit(input logic b);
    cs_n_q = 1'b0;
    sda_q = b;
    #400 sck_q = 1'b1;
    #400 sck_q = 1'b0;
    #400 cs_n_q = 1'b1;
    // Released line shows the inverse so a stale value cannot pass
    sda_q = ~b;
  endtask

  // Start, address byte MSB first, acknowledge slot, stop
  task automatic i2c_addr(input logic [7:0] a, output logic ack);
    sck_q = 1'b1;
    sda_q = 1'b1;
    #800 sda_q = 1'b0;
    #400 sck_q = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #200 sda_q = a[i];
      #200 sck_q = 1'b1;
      #400 sck_q = 1'b0;
    end
    // Long low phase leaves the synchronised slave time to pull the line
    #200 sda_q = 1'b1;
    #600 sck_q = 1'b1;
    #200 ack = sda_line;
    #200 sck_q = 1'b0;
    #200 sda_q = 1'b0;
    #200 sck_q = 1'b1;
    #400 sda_q = 1'b1;
  endtask
endmodule

/* verif/test_serial_host_port_select.sv */
// Self-checking bench for the serial host port select block.
// Assumes a 10 MHz clk_sys and a host model clocking pins at 800 ns.
`timescale 1ns/1ps
module test_serial_host_port_select
  import shps_pkg::*;
;
  // One expected result: which output, and its value
  typedef struct packed {logic [3:0] sel; logic [6:0] val;} shps_exp_t;
  logic clk_sys, arst_n, i2c_en_pin, spi_miso, status_change, isr_read, i2c_sda_pull;
  logic [2:0] strap;
  logic sck_scl_o_q, sck_scl_oe_n_q, si_sda_o_q, si_sda_oe_n_q, so_q, int_o_q, int_oe_n_q;
  logic i2c_mode_q, spi_sck_q, spi_mosi_q, spi_cs_n_q, i2c_hit_q, host_sck, host_sda, host_cs_n;
  logic i2c_rd_q, i2c_active_q, i2c_scl_q, i2c_sda_q;
  logic [6:0] i2c_slave_addr_q;
  logic b, ack_bit, rw;
  shps_exp_t exp_q[$];
  shps_exp_t mon_e;
  int err_count = 0;
  int check_count = 0;
  int hit_count = 0;
  int n, dummy;
  // Wired-AND pins with pull-ups; select pin is a board strap in I2C
  wire sck_line = host_sck & (sck_scl_oe_n_q | sck_scl_o_q);
  wire sda_line = host_sda & (si_sda_oe_n_q | si_sda_o_q);
  wire int_line = int_oe_n_q | int_o_q;
  wire sel_pin = i2c_en_pin ? strap[0] : host_cs_n;

  shps_port_sel i_shps_port_sel (.clk_sys(clk_sys), .arst_n(arst_n), .i2c_en_pin(i2c_en_pin),
    .sck_scl_i(sck_line), .sck_scl_o_q(sck_scl_o_q), .sck_scl_oe_n_q(sck_scl_oe_n_q),
    .si_sda_i(sda_line), .si_sda_o_q(si_sda_o_q), .si_sda_oe_n_q(si_sda_oe_n_q), .so_q(so_q),
    .select_or_addr_bit0_pin(sel_pin), .i2c_addr_bit1(strap[1]), .i2c_addr_bit2(strap[2]),
    .int_o_q(int_o_q), .int_oe_n_q(int_oe_n_q), .i2c_mode_q(i2c_mode_q), .spi_sck_q(spi_sck_q),
    .spi_mosi_q(spi_mosi_q), .spi_cs_n_q(spi_cs_n_q), .spi_miso(spi_miso),
    .i2c_slave_addr_q(i2c_slave_addr_q), .i2c_hit_q(i2c_hit_q), .i2c_rd_q(i2c_rd_q),
    .i2c_active_q(i2c_active_q), .i2c_scl_q(i2c_scl_q), .i2c_sda_q(i2c_sda_q),
    .i2c_sda_pull(i2c_sda_pull), .status_change(status_change),
    .isr_read(isr_read));
  shps_host_model i_shps_host_model (.sda_line(sda_line), .sck_q(host_sck), .sda_q(host_sda),
    .cs_n_q(host_cs_n));

  // Clock: 100 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Counts address-match pulses, which last one cycle only; sampled mid-cycle, clear of the launching edge
  always @(negedge clk_sys)
  begin
    if (i2c_hit_q === 1'b1)
      hit_count++;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic expect_val(input logic [3:0] sel, input logic [6:0] val);
    exp_q.push_back('{sel, val});
  endtask

  function automatic logic [6:0] observe(input logic [3:0] sel);
    case (sel)
      4'h0: return {6'h00, i2c_mode_q};
      4'h1: return {6'h00, spi_sck_q};
      4'h2: return {6'h00, spi_mosi_q};
      4'h3: return {6'h00, spi_cs_n_q};
      4'h4: return {6'h00, so_q};
      4'h5: return {6'h00, ack_bit};
      4'h6: return {6'h00, int_line};
      4'h7: return i2c_slave_addr_q;
      4'h8: return 7'(hit_count);
      4'h9: return {6'h00, si_sda_oe_n_q};
      4'ha: return {6'h00, i2c_active_q};
      4'hb: return {6'h00, i2c_rd_q};
      4'hc: return {6'h00, i2c_scl_q};
      4'hd: return {6'h00, i2c_sda_q};
      // Pin drives that must stay released: clock enable, clock value, data value
      default: return {4'h0, sck_scl_oe_n_q, sck_scl_o_q, si_sda_o_q};
    endcase
  endfunction

  // Monitor: falling edge, when outputs have settled, takes the oldest notes
  always @(negedge clk_sys)
  begin
    while (exp_q.size() > 0)
    begin
      mon_e = exp_q.pop_front();
      check_count++;
      if (observe(mon_e.sel) !== mon_e.val)
      begin
        err_count++;
        $display("wrong value at %0t: output %0d got %h not %h", $time, mon_e.sel, observe(mon_e.sel), mon_e.val);
      end
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 31 us the tests need
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end

  initial
  begin
    arst_n = 1'b0;
    i2c_en_pin = 1'b1;
    strap = 3'h7;
    spi_miso = 1'b0;
    status_change = 1'b0;
    isr_read = 1'b0;
    i2c_sda_pull = 1'b0;
    dummy = $urandom(65298);
    tick(8);
    arst_n = 1'b1;
    tick(4);
    expect_val(4'h0, 7'h01);
    expect_val(4'h7, {I2C_ADDR_HI, 3'h7});
    $display("test reset done");
    // SPI: pins reach the core side, select frames each bit
    i2c_en_pin = 1'b0;
    tick(4);
    expect_val(4'h0, 7'h00);
    expect_val(4'hc, 7'h01);
    expect_val(4'hd, 7'h01);
    expect_val(4'he, 7'h04);
    for (int k = 0; k < 4; k++)
    begin
      b = 1'($urandom);
      fork
        i_shps_host_model.spi_bit(b);
        begin
          #750;
          expect_val(4'h1, 7'h01);
          expect_val(4'h2, {6'h00, b});
          expect_val(4'h3, 7'h00);
        end
      join
      tick(4);
      expect_val(4'h3, 7'h01);
    end
    for (int k = 0; k < 8; k++)
    begin
      spi_miso = 1'($urandom);
      tick(1);
      expect_val(4'h4, {6'h00, spi_miso});
    end
    $display("test spi done");
    // I2C: straps form the address; only a matching address is acknowledged
    i2c_en_pin = 1'b1;
    strap = 3'($urandom);
    spi_miso = 1'b1;
    tick(4);
    expect_val(4'h7, {I2C_ADDR_HI, strap});
    expect_val(4'h4, 7'h00);
    expect_val(4'h3, 7'h01);
    expect_val(4'h1, 7'h00);
    expect_val(4'hc, {6'h00, host_sck});
    expect_val(4'hd, {6'h00, host_sda});
    expect_val(4'he, 7'h04);
    rw = 1'($urandom);
    for (int k = 0; k < 2; k++)
    begin
      n = hit_count;
      fork
        i_shps_host_model.i2c_addr({I2C_ADDR_HI, strap ^ 3'(k * 4), rw}, ack_bit);
        begin
          // Core asks for a pull in the data phase, before the stop; only an addressed slave drives
          #9100 i2c_sda_pull = 1'b1;
          #200;
          expect_val(4'h9, 7'(k));
          expect_val(4'ha, 7'(1 - k));
          i2c_sda_pull = 1'b0;
        end
      join
      // Stop reaches the sequencer through the synchroniser before active drops
      tick(5);
      expect_val(4'h5, 7'(k));
      expect_val(4'h8, 7'(n + 1 - k));
      expect_val(4'hb, {6'h00, rw});
      expect_val(4'ha, 7'h00);
    end
    $display("test i2c done");
    // Interrupt: set, set winning over a read, then cleared by a read
    status_change = 1'b1;
    tick(1);
    status_change = 1'b0;
    tick(1);
    expect_val(4'h6, 7'h00);
    status_change = 1'b1;
    isr_read = 1'b1;
    tick(1);
    status_change = 1'b0;
    isr_read = 1'b0;
    tick(3);
    expect_val(4'h6, 7'h00);
    isr_read = 1'b1;
    tick(1);
    isr_read = 1'b0;
    tick(3);
    expect_val(4'h6, 7'h01);
    tick(2);
    $display("test interrupt done");
    summarize();
  end
endmodule
